// ---- common/swirq_pkg.sv ----
// Constants and types of the switch event interrupt enable block
`default_nettype none
package swirq_pkg;
    // Register port geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam int NUM_CH = 12;
    localparam int EVT_W  = 12;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CH_EDGE_SEL = 6'h23;
    localparam logic [ADDR_W-1:0] OFF_EVT_EN      = 6'h24;

    // Reset values and writable masks
    localparam logic [DATA_W-1:0] RST_CH_EDGE_SEL = 24'h000000;
    localparam logic [DATA_W-1:0] RST_EVT_EN      = 24'h000000;
    localparam logic [DATA_W-1:0] MASK_CH_EDGE    = 24'hffffff;
    localparam logic [DATA_W-1:0] MASK_EVT_EN     = 24'h000fff;
    localparam logic [DATA_W-1:0] RD_UNMAPPED     = 24'h000000;

    // Edge-select field width and encodings
    localparam int SEL_W = 2;
    localparam logic [SEL_W-1:0] SEL_NONE    = 2'h0;
    localparam logic [SEL_W-1:0] SEL_RISE    = 2'h1;
    localparam logic [SEL_W-1:0] SEL_FALL    = 2'h2;
    localparam logic [SEL_W-1:0] SEL_BOTH    = 2'h3;

    // Event enable bit positions
    localparam int EV_CONV_ERR   = 11;
    localparam int EV_WET_ERR    = 10;
    localparam int EV_SUP_THR1   = 9;
    localparam int EV_SUP_THR0   = 8;
    localparam int EV_CHECKSUM   = 7;
    localparam int EV_SUP_LOW    = 6;
    localparam int EV_SUP_HIGH   = 5;
    localparam int EV_THERM_WARN = 4;
    localparam int EV_THERM_SD   = 3;
    localparam int EV_SHORT_SUP  = 2;
    localparam int EV_PARITY     = 1;
    localparam int EV_SER_FAIL   = 0;

    // Comparator results, channel 23 at the top, channel 12 at bit 0
    typedef struct packed {
        logic [3:0] grp_20_23;
        logic [3:0] grp_16_19;
        logic [3:0] grp_12_15;
    } swirq_cmp_t;

    // Event enables in register bit order
    typedef struct packed {
        logic conv_error_irq_en;
        logic wetting_error_irq_en;
        logic supply_sense_thr1_irq_en;
        logic supply_sense_thr0_irq_en;
        logic checksum_done_irq_en;
        logic supply_low_irq_en;
        logic supply_high_irq_en;
        logic thermal_warning_irq_en;
        logic thermal_shutdown_irq_en;
        logic short_to_supply_irq_en;
        logic parity_error_irq_en;
        logic serial_fail_irq_en;
    } swirq_evt_en_t;

    // Register access request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } swirq_req_t;
endpackage
`default_nettype wire

// ---- verilog/swirq_edge_hit.sv ----
// Per-channel crossing detector filtered by the edge-select fields
`default_nettype none
module swirq_edge_hit #(
    parameter int NCH = swirq_pkg::NUM_CH
) (
    // Programmed fields, two bits per channel
    input  wire logic [2*NCH-1:0] sel,
    // Comparator now and one cycle ago
    input  wire logic [NCH-1:0]   cmp_cur,
    input  wire logic [NCH-1:0]   cmp_prev,
    // Crossing qualifies for an interrupt
    output logic      [NCH-1:0]   hit
);
    // Decode one field against the seen crossing
    function automatic logic sel_hit(input logic [1:0] s,
                                     input logic rise,
                                     input logic fall);
        logic r;
        r = 1'b0;
        unique case (s)
            swirq_pkg::SEL_NONE: r = 1'b0;
            swirq_pkg::SEL_RISE: r = rise;
            swirq_pkg::SEL_FALL: r = fall;
            swirq_pkg::SEL_BOTH: r = rise | fall;
        endcase
        return r;
    endfunction

    // One decoder per channel, field k at bits 2k+1..2k
    for (genvar k = 0; k < NCH; k++) begin : g_ch
        assign hit[k] = sel_hit(sel[2*k+1 -: 2],
                                cmp_cur[k] & ~cmp_prev[k],
                                ~cmp_cur[k] & cmp_prev[k]);
    end
endmodule
`default_nettype wire

// ---- verilog/swirq_top.sv ----
// Interrupt enable logic for channels 12 to 23 and diagnostic events
`default_nettype none
// Behaviour
// R01: Field value 0 gives no channel interrupt at all.
// R02: Field value 1 interrupts on a rising threshold crossing.
// R03: Field value 2 interrupts on a falling threshold crossing.
// R04: Field value 3 interrupts on both crossing directions.
// R05: Channels 20-23 compare against threshold group 20-23.
// R06: Channels 16-19 compare against threshold group 16-19.
// R07: Channels 12-15 compare against threshold group 12-15.
// R08: Channel 12+k field sits at bits 2k+1..2k of edge-select register.
// R09: Edge-select fields are read/write and reset to zero.
// R10: Event enable bits 23..12 are read-only zero.
// R11: Bit 11 lets a conversion error assert the interrupt.
// R12: Bit 10 lets a wetting current error assert the interrupt.
// R13: Bits 9 and 8 gate supply-sense thresholds 1 and 0.
// R14: Bit 7 gates checksum calculation completion.
// R15: Bits 6 and 5 gate supply undervoltage and overvoltage.
// R16: Bits 4 and 3 gate thermal warning and thermal shutdown.
// R17: Bit 2 gates the switch short-to-supply event.
// R18: Bits 1 and 0 gate parity failure and serial failure; reset zero.
// R19: Interrupt output low while any enabled source is pending.
module swirq_top (
    // Clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             rst,
    // Register access
    input  wire swirq_pkg::swirq_req_t            reg_req,
    output logic      [swirq_pkg::DATA_W-1:0]     reg_rdata,
    output logic                                  reg_rvalid,
    // Comparator results per threshold group
    input  wire swirq_pkg::swirq_cmp_t            cmp_in,
    // Event flags pending outside, register bit order
    input  wire logic [swirq_pkg::EVT_W-1:0]      evt_pending,
    // Channel pending flags and their clear mask
    input  wire logic [swirq_pkg::NUM_CH-1:0]     ch_pend_clr,
    output logic      [swirq_pkg::NUM_CH-1:0]     ch_pend,
    // Interrupt output, active low
    output logic                                  irq_n
);
    localparam int NCH = swirq_pkg::NUM_CH;
    localparam int DW  = swirq_pkg::DATA_W;

    typedef struct packed {
        logic [DW-1:0]                 edge_sel;
        swirq_pkg::swirq_evt_en_t      evt_en;
        logic [NCH-1:0]                cmp_prev;
        logic                          primed;
        logic [NCH-1:0]                pend;
        logic                          irq_n;
        logic [DW-1:0]                 rdata;
        logic                          rvalid;
    } swirq_state_t;

    swirq_state_t   st_r;
    swirq_state_t   st_nxt;
    logic [NCH-1:0] cmp_cur;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] hit_q;
    logic           evt_any;

    // Channel order of the groups: 23..20, 19..16, 15..12
    assign cmp_cur = {cmp_in.grp_20_23,                   // [R05]
                      cmp_in.grp_16_19,                   // [R06]
                      cmp_in.grp_12_15};                  // [R07]

    // Crossing filter per channel
    swirq_edge_hit #(
        .NCH      (NCH)
    ) u_edge (
        .sel      (st_r.edge_sel),
        .cmp_cur  (cmp_cur),
        .cmp_prev (st_r.cmp_prev),
        .hit      (hit)
    );

    // First sample after reset only primes the history
    // Without it a line already high at reset release would look
    // like a rising crossing against the cleared history
    assign hit_q   = st_r.primed ? hit : '0;
    // Enabled diagnostic sources
    assign evt_any = |(evt_pending & st_r.evt_en);  // [R11] [R12] [R13]

    // Read multiplexer
    function automatic logic [DW-1:0] rd_mux(
        input logic [swirq_pkg::ADDR_W-1:0] a,
        input logic [DW-1:0]                sel_v,
        input logic [DW-1:0]                evt_v);
        logic [DW-1:0] r;
        r = swirq_pkg::RD_UNMAPPED;
        if (a == swirq_pkg::OFF_CH_EDGE_SEL) begin
            r = sel_v;
        end else if (a == swirq_pkg::OFF_EVT_EN) begin
            r = evt_v & swirq_pkg::MASK_EVT_EN;           // [R10]
        end
        return r;
    endfunction

    // Next state
    always_comb begin
        st_nxt          = st_r;
        st_nxt.cmp_prev = cmp_cur;
        st_nxt.primed   = 1'b1;
        st_nxt.rvalid   = reg_req.rd;
        if (reg_req.rd) begin
            st_nxt.rdata = rd_mux(reg_req.addr, st_r.edge_sel,
                                  {{(DW-swirq_pkg::EVT_W){1'b0}},
                                   st_r.evt_en});
        end
        // Register writes
        if (reg_req.wr &&
            reg_req.addr == swirq_pkg::OFF_CH_EDGE_SEL) begin
            st_nxt.edge_sel = reg_req.wdata
                              & swirq_pkg::MASK_CH_EDGE;  // [R08] [R09]
        end
        if (reg_req.wr && reg_req.addr == swirq_pkg::OFF_EVT_EN) begin
            st_nxt.evt_en = reg_req.wdata[swirq_pkg::EVT_W-1:0]; // [R14]
        end
        // Pending flags; a new hit wins over a clear
        st_nxt.pend  = (st_r.pend & ~ch_pend_clr) | hit_q;  // [R01] [R02]
        // Interrupt pin follows enabled pending sources
        st_nxt.irq_n = ~(evt_any | (|st_r.pend));  // [R19] [R15] [R16]
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r.edge_sel <= swirq_pkg::RST_CH_EDGE_SEL;  // [R09]
            st_r.evt_en   <= swirq_pkg::RST_EVT_EN[swirq_pkg::EVT_W-1:0];
            st_r.cmp_prev <= '0;
            st_r.primed   <= 1'b0;
            st_r.pend     <= '0;
            st_r.irq_n    <= 1'b1;
            st_r.rdata    <= '0;
            st_r.rvalid   <= 1'b0;                        // [R18] [R17]
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata  = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign ch_pend    = st_r.pend;
    assign irq_n      = st_r.irq_n;

    // Helper vectors for the checks below
    logic [NCH-1:0] rise_v;
    logic [NCH-1:0] fall_v;
    logic [NCH-1:0] b0_v;
    logic [NCH-1:0] b1_v;
    logic [NCH-1:0] new_pend;
    logic           quiet;

    assign rise_v   = cmp_cur & ~st_r.cmp_prev;
    assign fall_v   = ~cmp_cur & st_r.cmp_prev;
    assign new_pend = st_nxt.pend & ~st_r.pend;
    // No enabled source pending anywhere
    assign quiet    = (evt_pending & st_r.evt_en) == '0 && st_r.pend == '0;
    for (genvar k = 0; k < NCH; k++) begin : g_bits
        assign b0_v[k] = st_r.edge_sel[2*k];
        assign b1_v[k] = st_r.edge_sel[2*k+1];
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Channel crossings against their programmed field
    sel_none_a: assert property (                         // [R01]
        ((st_r.pend & ~$past(st_r.pend)) & ~$past(b0_v | b1_v)) == '0)
        else $error("pending set on a disabled channel");
    sel_rise_a: assert property (                         // [R02]
        st_r.primed |=> ($past(rise_v & b0_v & ~b1_v) & ~st_r.pend) == '0)
        else $error("rising crossing not latched");
    sel_fall_a: assert property (                         // [R03]
        st_r.primed |=> ($past(fall_v & b1_v & ~b0_v) & ~st_r.pend) == '0)
        else $error("falling crossing not latched");
    sel_both_a: assert property (                         // [R04]
        st_r.primed
        |=> ($past((rise_v | fall_v) & b0_v & b1_v) & ~st_r.pend) == '0)
        else $error("crossing in both-edge mode not latched");

    // Group mapping, one channel of each group
    grp_20_23_a: assert property (                        // [R05]
        st_r.primed && st_r.edge_sel[17:16] == swirq_pkg::SEL_RISE
        && cmp_in.grp_20_23[0] && !st_r.cmp_prev[8] |=> st_r.pend[8])
        else $error("channel 20 not taken from group 20-23");
    grp_16_19_a: assert property (                        // [R06]
        st_r.primed && st_r.edge_sel[15:14] == swirq_pkg::SEL_FALL
        && !cmp_in.grp_16_19[3] && st_r.cmp_prev[7] |=> st_r.pend[7])
        else $error("channel 19 not taken from group 16-19");
    grp_12_15_a: assert property (                        // [R07]
        st_r.primed && st_r.edge_sel[1:0] == swirq_pkg::SEL_BOTH
        && cmp_in.grp_12_15[0] != st_r.cmp_prev[0] |=> st_r.pend[0])
        else $error("channel 12 not taken from group 12-15");

    // Register behaviour
    sel_write_a: assert property (                        // [R08]
        reg_req.wr && reg_req.addr == swirq_pkg::OFF_CH_EDGE_SEL
        |=> st_r.edge_sel == $past(reg_req.wdata))
        else $error("edge-select write not stored");
    sel_reset_a: assert property (                        // [R09]
        $past(rst) |-> st_r.edge_sel == '0 && st_r.pend == '0)
        else $error("edge-select not zero after reset");
    evt_resv_a: assert property (                         // [R10]
        reg_req.rd && reg_req.addr == swirq_pkg::OFF_EVT_EN
        |=> reg_rvalid && reg_rdata[23:12] == 12'h000)
        else $error("reserved event bits read nonzero");
    evt_rst_a: assert property (                          // [R18]
        $past(rst) |-> st_r.evt_en == '0 && irq_n)
        else $error("event enables not zero after reset");

    // Interrupt pin tied to enabled sources
    irq_gate_a: assert property (          // [R11] [R12] [R13] [R14] [R19]
        ##1 irq_n == !($past(|(evt_pending & st_r.evt_en))
                       || $past(|st_r.pend)))
        else $error("interrupt pin disagrees with enabled sources");
    evt_mask_a: assert property (                  // [R15] [R16] [R17]
        (evt_pending & st_r.evt_en) == '0 && st_r.pend == '0
        |=> irq_n)
        else $error("masked event asserted the interrupt");

    // Each event enable bit opens its own source
    conv_gate_a: assert property (                        // [R11]
        evt_pending[swirq_pkg::EV_CONV_ERR]
        && st_r.evt_en.conv_error_irq_en |=> !irq_n)
        else $error("enabled conversion error did not assert");
    wet_gate_a: assert property (                         // [R12]
        evt_pending[swirq_pkg::EV_WET_ERR]
        && st_r.evt_en.wetting_error_irq_en |=> !irq_n)
        else $error("enabled wetting error did not assert");
    thr1_gate_a: assert property (                        // [R13]
        evt_pending[swirq_pkg::EV_SUP_THR1]
        && st_r.evt_en.supply_sense_thr1_irq_en |=> !irq_n)
        else $error("enabled supply threshold 1 did not assert");
    thr0_gate_a: assert property (                        // [R13]
        evt_pending[swirq_pkg::EV_SUP_THR0]
        && st_r.evt_en.supply_sense_thr0_irq_en |=> !irq_n)
        else $error("enabled supply threshold 0 did not assert");
    sum_gate_a: assert property (                         // [R14]
        evt_pending[swirq_pkg::EV_CHECKSUM]
        && st_r.evt_en.checksum_done_irq_en |=> !irq_n)
        else $error("enabled checksum done did not assert");
    low_gate_a: assert property (                         // [R15]
        evt_pending[swirq_pkg::EV_SUP_LOW]
        && st_r.evt_en.supply_low_irq_en |=> !irq_n)
        else $error("enabled undervoltage did not assert");
    high_gate_a: assert property (                        // [R15]
        evt_pending[swirq_pkg::EV_SUP_HIGH]
        && st_r.evt_en.supply_high_irq_en |=> !irq_n)
        else $error("enabled overvoltage did not assert");
    warn_gate_a: assert property (                        // [R16]
        evt_pending[swirq_pkg::EV_THERM_WARN]
        && st_r.evt_en.thermal_warning_irq_en |=> !irq_n)
        else $error("enabled thermal warning did not assert");
    sd_gate_a: assert property (                          // [R16]
        evt_pending[swirq_pkg::EV_THERM_SD]
        && st_r.evt_en.thermal_shutdown_irq_en |=> !irq_n)
        else $error("enabled thermal shutdown did not assert");
    short_gate_a: assert property (                       // [R17]
        evt_pending[swirq_pkg::EV_SHORT_SUP]
        && st_r.evt_en.short_to_supply_irq_en |=> !irq_n)
        else $error("enabled short to supply did not assert");
    par_gate_a: assert property (                         // [R18]
        evt_pending[swirq_pkg::EV_PARITY]
        && st_r.evt_en.parity_error_irq_en |=> !irq_n)
        else $error("enabled parity error did not assert");
    ser_gate_a: assert property (                         // [R18]
        evt_pending[swirq_pkg::EV_SER_FAIL]
        && st_r.evt_en.serial_fail_irq_en |=> !irq_n)
        else $error("enabled serial failure did not assert");

    // Each clear enable bit keeps its own source off the pin
    conv_mask_a: assert property (                        // [R11]
        evt_pending[swirq_pkg::EV_CONV_ERR] && quiet |=> irq_n)
        else $error("disabled conversion error asserted");
    wet_mask_a: assert property (                         // [R12]
        evt_pending[swirq_pkg::EV_WET_ERR] && quiet |=> irq_n)
        else $error("disabled wetting error asserted");
    thr1_mask_a: assert property (                        // [R13]
        evt_pending[swirq_pkg::EV_SUP_THR1] && quiet |=> irq_n)
        else $error("disabled supply threshold 1 asserted");
    thr0_mask_a: assert property (                        // [R13]
        evt_pending[swirq_pkg::EV_SUP_THR0] && quiet |=> irq_n)
        else $error("disabled supply threshold 0 asserted");
    sum_mask_a: assert property (                         // [R14]
        evt_pending[swirq_pkg::EV_CHECKSUM] && quiet |=> irq_n)
        else $error("disabled checksum done asserted");
    low_mask_a: assert property (                         // [R15]
        evt_pending[swirq_pkg::EV_SUP_LOW] && quiet |=> irq_n)
        else $error("disabled undervoltage asserted");
    high_mask_a: assert property (                        // [R15]
        evt_pending[swirq_pkg::EV_SUP_HIGH] && quiet |=> irq_n)
        else $error("disabled overvoltage asserted");
    warn_mask_a: assert property (                        // [R16]
        evt_pending[swirq_pkg::EV_THERM_WARN] && quiet |=> irq_n)
        else $error("disabled thermal warning asserted");
    sd_mask_a: assert property (                          // [R16]
        evt_pending[swirq_pkg::EV_THERM_SD] && quiet |=> irq_n)
        else $error("disabled thermal shutdown asserted");
    short_mask_a: assert property (                       // [R17]
        evt_pending[swirq_pkg::EV_SHORT_SUP] && quiet |=> irq_n)
        else $error("disabled short to supply asserted");
    par_mask_a: assert property (                         // [R18]
        evt_pending[swirq_pkg::EV_PARITY] && quiet |=> irq_n)
        else $error("disabled parity error asserted");
    ser_mask_a: assert property (                         // [R18]
        evt_pending[swirq_pkg::EV_SER_FAIL] && quiet |=> irq_n)
        else $error("disabled serial failure asserted");

    // Read answers and pending bookkeeping
    evt_write_a: assert property (                        // [R14]
        reg_req.wr && reg_req.addr == swirq_pkg::OFF_EVT_EN
        |=> st_r.evt_en == $past(reg_req.wdata[11:0]))
        else $error("event enable write not stored");
    rvalid_pulse_a: assert property (                     // [R10]
        !reg_req.rd |=> !reg_rvalid)
        else $error("read answer without a read");
    rdata_hold_a: assert property (                       // [R10]
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    unmapped_rd_a: assert property (                      // [R10]
        reg_req.rd && reg_req.addr != swirq_pkg::OFF_CH_EDGE_SEL
        && reg_req.addr != swirq_pkg::OFF_EVT_EN
        |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    pend_clr_a: assert property (                         // [R19]
        ch_pend_clr != '0
        |=> (st_r.pend & $past(ch_pend_clr & ~hit_q)) == '0)
        else $error("cleared pending flag still set");
    pend_hold_a: assert property (                        // [R19]
        st_r.pend != '0
        |=> ($past(st_r.pend & ~ch_pend_clr) & ~st_r.pend) == '0)
        else $error("pending flag dropped without a clear");

    // Main scenarios
    rise_c: cover property (
        st_r.edge_sel[1:0] == swirq_pkg::SEL_RISE ##1 st_r.pend[0]);
    evt_irq_c: cover property (
        st_r.evt_en[swirq_pkg::EV_CONV_ERR]
        && evt_pending[swirq_pkg::EV_CONV_ERR] ##1 !irq_n);
    clr_c: cover property (st_r.pend[0] ##1 ch_pend_clr[0] ##1 irq_n);
    both_c: cover property (
        st_r.edge_sel[23:22] == swirq_pkg::SEL_BOTH ##1 st_r.pend[11]);
endmodule
`default_nettype wire

// ---- dv/swirq_host.sv ----
// Host microcontroller model issuing register accesses to the block
`default_nettype none
module swirq_host (
    // Clock
    input  wire logic                         clk_sys,
    // Request out, answer in
    output var  swirq_pkg::swirq_req_t        reg_req,
    input  wire logic [swirq_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                         reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle request at time zero
    initial reg_req = '0;

    // Write held across the one edge that takes it
    task automatic wr(input logic [5:0] a, input logic [23:0] dat);
        @(negedge clk_sys);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
        @(negedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dat};
    endtask

    // Read, answer taken half a cycle after the request edge
    task automatic rd(input logic [5:0] a, output logic [23:0] dat,
                      output logic vld);
        @(negedge clk_sys);
        reg_req.rd   <= 1'b1;
        reg_req.addr <= a;
        @(negedge clk_sys);
        reg_req.rd   <= 1'b0;
        reg_req.addr <= ~a;
        vld = reg_rvalid;
        dat = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- dv/swirq_top_tb.sv ----
// Self-checking bench of the switch event interrupt enable block
`default_nettype none
module swirq_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk_sys = 1'b0;
    logic                  rst     = 1'b1;
    swirq_pkg::swirq_req_t req;
    logic [23:0]           rdata;
    logic                  rvalid;
    swirq_pkg::swirq_cmp_t cmp     = '0;
    logic [11:0]           evt     = '0;
    logic [11:0]           clr     = '0;
    logic [11:0]           pend;
    logic                  irq_n;
    int                    error_cnt  = 0;
    int                    n_compared = 0;

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    // Block under test and host model
    swirq_top u_swirq_top (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .reg_req    (req),
        .reg_rdata  (rdata),
        .reg_rvalid (rvalid),
        .cmp_in     (cmp),
        .evt_pending(evt),
        .ch_pend_clr(clr),
        .ch_pend    (pend),
        .irq_n      (irq_n)
    );
    swirq_host u_swirq_host (
        .clk_sys   (clk_sys),
        .reg_req   (req),
        .reg_rdata (rdata),
        .reg_rvalid(rvalid)
    );

    // Compare and count
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Read one register and compare answer strobe and data
    task automatic rdchk(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] dat;
        logic        vld;
        u_swirq_host.rd(a, dat, vld);
        chk({23'h0, vld}, 24'h1);
        chk(dat, exp);
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Values after reset, unmapped read
    task automatic t_reset;
        chk({23'h0, irq_n}, 24'h1);
        rdchk(swirq_pkg::OFF_CH_EDGE_SEL, 24'h0);
        rdchk(swirq_pkg::OFF_EVT_EN, 24'h0);
        rdchk(6'h25, 24'h0);
        $display("reset test done");
    endtask

    // Access kinds, reserved bits, ignored unmapped write
    task automatic t_regs;
        u_swirq_host.wr(swirq_pkg::OFF_CH_EDGE_SEL, 24'hffffff);
        rdchk(swirq_pkg::OFF_CH_EDGE_SEL, 24'hffffff);
        u_swirq_host.wr(swirq_pkg::OFF_EVT_EN, 24'hffffff);
        rdchk(swirq_pkg::OFF_EVT_EN, 24'h000fff);
        u_swirq_host.wr(6'h25, 24'h123456);
        rdchk(6'h25, 24'h0);
        u_swirq_host.wr(swirq_pkg::OFF_CH_EDGE_SEL, 24'h0);
        u_swirq_host.wr(swirq_pkg::OFF_EVT_EN, 24'h0);
        $display("register test done");
    endtask

    // One crossing on channel k, then pending, interrupt and clear
    task automatic step(input int k, input logic lv, input logic e);
        logic [11:0] m;
        m = 12'h1 << k;
        cmp = swirq_pkg::swirq_cmp_t'(lv ? m : 12'h0);
        @(negedge clk_sys);
        chk(24'(pend), e ? 24'(m) : 24'h0);
        @(negedge clk_sys);
        chk({23'h0, irq_n}, {23'h0, !e});
        clr = m;
        @(negedge clk_sys);
        clr = '0;
        @(negedge clk_sys);
        chk({11'h0, pend, irq_n}, 24'h1);
    endtask

    // Every field value on every channel of all three groups
    task automatic t_edges;
        for (int k = 0; k < 12; k++) begin
            for (int s = 0; s < 4; s++) begin
                u_swirq_host.wr(swirq_pkg::OFF_CH_EDGE_SEL,
                                24'(s) << (2 * k));
                step(k, 1'b1, s[0]);
                step(k, 1'b0, s[1]);
            end
        end
        $display("edge select test done");
    endtask

    // Each event enable gates only its own source
    task automatic t_events;
        for (int b = 0; b < 12; b++) begin
            u_swirq_host.wr(swirq_pkg::OFF_EVT_EN, 24'h1 << b);
            evt = ~(12'h1 << b);
            @(negedge clk_sys);
            @(negedge clk_sys);
            chk({23'h0, irq_n}, 24'h1);
            evt = 12'h1 << b;
            @(negedge clk_sys);
            chk({23'h0, irq_n}, 24'h0);
            evt = '0;
            @(negedge clk_sys);
            chk({23'h0, irq_n}, 24'h1);
        end
        $display("event enable test done");
    endtask

    // Reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        t_reset;
        t_regs;
        t_edges;
        t_events;
        test_done;
    end
endmodule
`default_nettype wire
